// ===== logic/ssr_params.svh
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// clock period of the cpu clock
`define SSR_CLK_NS          100
// least pulse on the reset pin after a watchdog or pin reset
`define SSR_PULSE_NS        20000
`define SSR_PULSE_CYCLES    ((`SSR_PULSE_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS)

// register map, byte addresses
`define SSR_OFS_STATUS      32'h0000_0000
`define SSR_ADDR_BITS       4

// status register fields
`define SSR_BIT_IRQ_EN      6
`define SSR_BIT_WARN        5
`define SSR_BIT_LVD_RF      4
`define SSR_BIT_LOCKED      3
`define SSR_BIT_WDG_RF      0
`define SSR_STATUS_RESET    8'h00

// option values
`define SSR_LEVEL_LOW       2'h0
`define SSR_LEVEL_MED       2'h1
`define SSR_LEVEL_HIGH      2'h2

// ahb codes
`define SSR_HTRANS_NONSEQ   2'h2
`define SSR_HTRANS_SEQ      2'h3

`endif

// ===== logic/ssr_pkg.sv
package ssr_pkg;

  // asynchronous analog and pin levels, all active high
  typedef struct packed {
    logic lvdAboveRise;
    logic lvdAboveFall;
    logic warnBelowFall;
    logic warnAboveRise;
    logic pllLock;
    logic rstPinHigh;
  } ssr_sense_type;

  // ahb-lite request signals from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ssr_ahb_req_type;

  // reset pin sequencer states
  typedef enum logic [2:0] {
    SSR_IDLE     = 3'b001,
    SSR_LVD_HOLD = 3'b010,
    SSR_PULSE    = 3'b100
  } ssr_state_type;

endpackage

// ===== logic/ssr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssr_params.svh"

// Notes on behaviour
// - enabled detector holds reset with hysteresis
// - watchdog underflow drives pin for least pulse
// - low-voltage reset keeps pin driven low
// - detector optional; warning needs it enabled
// - threshold chosen low, medium or high
// - falling warning sets flag, requests interrupt
// - rising warning clears flag, no interrupt
// - bit 6 enables warning interrupt on fall
// - pending cleared on entering service routine
// - bit 5 read-only warning flag
// - bit 4 set by low-voltage reset, write-zero clears
// - later resets keep low-voltage flag
// - bit 3 shows pll locked
// - bit 0 watchdog flag, cleared by low voltage
// - flags record watchdog and low voltage; pin reset sets none
// - bits 7, 2, 1 read zero
// - register frozen in halt except reset flags
// - warning wakes wait, not halt
// - interrupt needs enable and cleared cpu mask
// - register resets to all zero, power-up sets no cause flag
module ssr_supervisor #(
  parameter int unsigned PULSE_CYCLES = `SSR_PULSE_CYCLES,
  parameter int unsigned CNT_W        = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // ahb-lite slave
  input  wire ssr_pkg::ssr_ahb_req_type ahbReq,
  input  wire logic [31:0]              hwdata,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // supply comparators, pll, pin read-back
  input  wire ssr_pkg::ssr_sense_type   sense,
  // option straps
  input  wire logic                     lvdEnableOpt,
  input  wire logic [1:0]               lvdLevelOpt,
  // cpu side
  input  wire logic                     wdgUnderflow,
  input  wire logic                     cpuIntMask,
  input  wire logic                     irqAck,
  input  wire logic                     haltMode,
  input  wire logic                     waitMode,
  output logic                          warnIrq,
  output logic                          waitWake,
  output logic                          coreReset_b,
  output logic [1:0]                    lvdLevel,
  output logic                          lvdEnable,
  // open-drain reset pin
  output logic                          rstPinOut,
  output logic                          rstPinOe_b
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // a change counts once the second and third stages agree

  localparam int SW = $bits(ssr_pkg::ssr_sense_type);

  logic [SW-1:0] syncA_r;
  logic [SW-1:0] syncB_r;
  logic [SW-1:0] syncC_r;
  logic [SW-1:0] sensed_r;
  logic [SW-1:0] sensedNxt;
  ssr_pkg::ssr_sense_type sv;

  assign sensedNxt = (syncB_r & syncC_r) | (sensed_r & (syncB_r ^ syncC_r));
  assign sv        = ssr_pkg::ssr_sense_type'(sensed_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r  <= '0;
      syncB_r  <= '0;
      syncC_r  <= '0;
      sensed_r <= '0;
    end else begin
      syncA_r  <= sense;
      syncB_r  <= syncA_r;
      syncC_r  <= syncB_r;
      sensed_r <= sensedNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option straps, sampled on every clock from release

  logic       lvdEn_r;
  logic [1:0] level_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvdEn_r <= 1'b0;
      level_r <= `SSR_LEVEL_LOW;
    end else begin
      lvdEn_r <= lvdEnableOpt;
      level_r <= (lvdLevelOpt == `SSR_LEVEL_HIGH) ? `SSR_LEVEL_HIGH :
                 (lvdLevelOpt == `SSR_LEVEL_MED)  ? `SSR_LEVEL_MED  :
                                                    `SSR_LEVEL_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low-voltage hold and reset pin sequencer

  ssr_pkg::ssr_state_type state_r;
  ssr_pkg::ssr_state_type stateNxt;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cntNxt;
  logic                   lvdLow;
  logic                   lvdSet;
  logic                   wdgSet;
  logic                   extSet;
  logic                   drivePin;
  logic                   pinArmed_r;
  logic                   optSeen_r;

  // hysteresis: hold until above rising, enter below falling
  assign lvdLow = lvdEn_r &&
                  ((state_r == ssr_pkg::SSR_LVD_HOLD) ? !sv.lvdAboveRise
                                                      : !sv.lvdAboveFall);
  // the read-back lags the pin by the synchroniser, so after our own drive
  // a low only counts once the pin has been seen high again
  assign extSet = (state_r == ssr_pkg::SSR_IDLE) && pinArmed_r &&
                  !sv.rstPinHigh;
  assign wdgSet = wdgUnderflow && !lvdLow;
  assign lvdSet = lvdLow && (state_r != ssr_pkg::SSR_LVD_HOLD);

  always_comb begin
    stateNxt = state_r;
    cntNxt   = cnt_r;
    unique case (state_r)
      ssr_pkg::SSR_IDLE: begin
        if (lvdLow) begin
          stateNxt = ssr_pkg::SSR_LVD_HOLD;
        end else if (wdgUnderflow || extSet) begin
          stateNxt = ssr_pkg::SSR_PULSE;
          cntNxt   = CNT_W'(PULSE_CYCLES - 1);
        end
      end
      ssr_pkg::SSR_LVD_HOLD: begin
        // release only once supply is above rising threshold
        // and the straps have been sampled at least once
        if (!lvdLow && optSeen_r) begin
          stateNxt = ssr_pkg::SSR_PULSE;
          cntNxt   = CNT_W'(PULSE_CYCLES - 1);
        end
      end
      ssr_pkg::SSR_PULSE: begin
        if (lvdLow) begin
          stateNxt = ssr_pkg::SSR_LVD_HOLD;
        end else if (cnt_r == '0) begin
          stateNxt = ssr_pkg::SSR_IDLE;
        end else begin
          cntNxt = cnt_r - CNT_W'(1);
        end
      end
    endcase
  end

  // pin driven low during hold and pulse
  assign drivePin = (stateNxt != ssr_pkg::SSR_IDLE);

  // straps are valid one clock after release; pin re-arms when seen high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      optSeen_r  <= 1'b0;
      pinArmed_r <= 1'b0;
    end else begin
      optSeen_r  <= 1'b1;
      pinArmed_r <= !drivePin && (pinArmed_r || sv.rstPinHigh);
    end
  end

  // power-up starts in hold so the first release waits for the supply
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ssr_pkg::SSR_LVD_HOLD;
      cnt_r   <= '0;
    end else begin
      state_r <= stateNxt;
      cnt_r   <= cntNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic       wrPend_r;
  logic       wrHit;
  logic       rdHit;
  logic       addrOk;
  logic       active;
  logic [7:0] wrByte;

  localparam logic [31:0] STATUS_OFS = `SSR_OFS_STATUS;

  assign active = ahbReq.hsel && ahbReq.hready &&
                  (ahbReq.htrans == `SSR_HTRANS_NONSEQ ||
                   ahbReq.htrans == `SSR_HTRANS_SEQ);
  assign addrOk = (ahbReq.haddr[`SSR_ADDR_BITS-1:0] ==
                   STATUS_OFS[`SSR_ADDR_BITS-1:0]);
  assign rdHit  = active && !ahbReq.hwrite && addrOk;
  assign wrHit  = wrPend_r && !haltMode;
  assign wrByte = hwdata[7:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
    end else begin
      wrPend_r <= active && ahbReq.hwrite && addrOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register and warning interrupt

  logic irqEn_r;
  logic warn_r;
  logic low_voltage_reset_flag_r;
  logic locked_r;
  logic watchdog_reset_flag_r;
  logic pend_r;
  logic irqEnNxt;
  logic warnNxt;
  logic lvdRfNxt;
  logic lockedNxt;
  logic wdgRfNxt;
  logic pendNxt;
  logic warnRise;
  logic [7:0] statusNxt;

  // halt freezes the register; reset causes still land
  assign irqEnNxt  = wrHit ? wrByte[`SSR_BIT_IRQ_EN] : irqEn_r;
  assign warnNxt   = haltMode ? warn_r :
                     !lvdEn_r ? 1'b0 :
                     sv.warnBelowFall ? 1'b1 :
                     sv.warnAboveRise ? 1'b0 : warn_r;
  // set wins, only a zero write clears
  assign lvdRfNxt  = lvdSet ||
                     (low_voltage_reset_flag_r && !(wrHit && !wrByte[`SSR_BIT_LVD_RF]));
  assign lockedNxt = haltMode ? locked_r : sv.pllLock;
  // low voltage clears the watchdog flag
  assign wdgRfNxt  = lvdSet ? 1'b0 :
                     wdgSet ||
                     (watchdog_reset_flag_r && !(wrHit && !wrByte[`SSR_BIT_WDG_RF]));
  assign warnRise  = warnNxt && !warn_r;
  // ack clears pending; a new rise in the same cycle wins
  assign pendNxt   = (warnRise && irqEnNxt) || (pend_r && !irqAck);

  assign statusNxt = {1'b0, irqEnNxt, warnNxt, lvdRfNxt, lockedNxt,
                      2'b00, wdgRfNxt};

  // all zero at power reset; the power-up hold sets no cause flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn_r  <= 1'b0;
      warn_r   <= 1'b0;
      low_voltage_reset_flag_r  <= 1'b0;
      locked_r <= 1'b0;
      watchdog_reset_flag_r  <= 1'b0;
      pend_r   <= 1'b0;
    end else begin
      irqEn_r  <= irqEnNxt;
      warn_r   <= warnNxt;
      low_voltage_reset_flag_r  <= lvdRfNxt;
      locked_r <= lockedNxt;
      watchdog_reset_flag_r  <= wdgRfNxt;
      pend_r   <= pendNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  // read data comes from next values so a read right after a write
  // already sees it

  // bus outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= rdHit ? {24'h00_0000, statusNxt} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // interrupt and wake outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warnIrq  <= 1'b0;
      waitWake <= 1'b0;
    end else begin
      warnIrq  <= pendNxt && !cpuIntMask;
      // wake from wait only; halt has no exit here
      waitWake <= pendNxt && waitMode && !haltMode;
    end
  end

  // reset pin and option outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coreReset_b <= 1'b0;
      lvdLevel    <= `SSR_LEVEL_LOW;
      lvdEnable   <= 1'b0;
      rstPinOut   <= 1'b0;
      rstPinOe_b  <= 1'b0;
    end else begin
      // core held while pin low, driven or external
      coreReset_b <= !drivePin && sv.rstPinHigh;
      lvdLevel    <= level_r;
      lvdEnable   <= lvdEn_r;
      rstPinOut   <= 1'b0;
      rstPinOe_b  <= !drivePin;
    end
  end

endmodule
`default_nettype wire

// ===== tb/ssr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_pin_model (
  input  wire logic rstPinOe_b,
  input  wire logic extLow,
  output var logic  pinHigh
);
  always_comb pinHigh = rstPinOe_b && !extLow;
endmodule
`default_nettype wire

// ===== tb/ssr_supervisor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor_chk #(
  parameter int unsigned PULSE_CYCLES = 4
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [31:0]            hrdata,
  input wire ssr_pkg::ssr_sense_type sense,
  input wire logic                   lvdEnableOpt,
  input wire logic [1:0]             lvdLevelOpt,
  input wire logic                   wdgUnderflow,
  input wire logic                   cpuIntMask,
  input wire logic                   irqAck,
  input wire logic                   haltMode,
  input wire logic                   waitMode,
  input wire logic                   warnIrq,
  input wire logic                   waitWake,
  input wire logic                   coreReset_b,
  input wire logic [1:0]             lvdLevel,
  input wire logic                   lvdEnable,
  input wire logic                   rstPinOut,
  input wire logic                   rstPinOe_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // counts driven-low cycles; repetition would not scale with the pulse
  int unsigned lowCnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lowCnt_r <= 0;
    else lowCnt_r <= rstPinOe_b ? 0 : lowCnt_r + 1;
  end
  // options pass two flops; compare once both hold post-reset values
  logic [1:0] upCnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
  end
  sequence supplyLow;
    (lvdEnable && !sense.lvdAboveFall) [*8];
  endsequence
  sequence wdgCause;
    wdgUnderflow && rstPinOe_b;
  endsequence
  ////////////////////////////////////////
  chk_lvd_hold: assert property (supplyLow |-> !rstPinOe_b)
    else $error("pin released while supply low");
  chk_pin_od: assert property (!rstPinOe_b |-> !rstPinOut ##[0:1] !coreReset_b)
    else $error("pin not driven low or core not reset");
  chk_wdg_start: assert property (wdgCause |=> !rstPinOe_b)
    else $error("watchdog did not drive pin");
  chk_pulse_len: assert property ($rose(rstPinOe_b) |-> lowCnt_r >= PULSE_CYCLES)
    else $error("reset pulse too short");
  chk_irq_mask: assert property (cpuIntMask |=> !warnIrq)
    else $error("irq while masked");
  chk_irq_ack: assert property (irqAck |=> !warnIrq)
    else $error("irq kept after ack");
  chk_wake_halt: assert property (waitWake |-> $past(waitMode) && !$past(haltMode))
    else $error("wake outside wait or in halt");
  chk_opt_follow: assert property (upCnt_r == 2'h3 |->
    lvdEnable == $past(lvdEnableOpt, 2) &&
    lvdLevel == (($past(lvdLevelOpt, 2) == 2'h3) ? 2'h0 :
                 $past(lvdLevelOpt, 2)))
    else $error("option not followed");
  chk_rsvd_zero: assert property (hrdata[31:8] == 0 && !hrdata[7] && hrdata[2:1] == 0)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ===== tb/ssr_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor_tb;
  logic        clk = 0, rst_b = 0, sel = 0, wr = 0, extLow = 0, pinHigh;
  logic        wdgUnderflow = 0, cpuIntMask = 0, irqAck = 0, haltMode = 0;
  logic        waitMode = 0, lvdEnableOpt = 1, hreadyout, hresp, warnIrq;
  logic        waitWake, coreReset_b, lvdEnable, rstPinOut, rstPinOe_b;
  logic [1:0]  trans = 0, lvdLevelOpt = 1, lvdLevel;
  logic [4:0]  sup = 5'b11010;
  logic [31:0] addr = 0, hwdata = 0, hrdata, rd;
  int          fails = 0, checks_done = 0;
  ssr_pkg::ssr_ahb_req_type req;
  ssr_pkg::ssr_sense_type   sense;
  assign req = '{sel, addr, trans, wr, 3'h2, hreadyout};
  assign sense = {sup, pinHigh};
  ssr_supervisor #(.PULSE_CYCLES(4)) DUT (.clk, .rst_b, .ahbReq(req), .hwdata,
    .hrdata, .hreadyout, .hresp, .sense, .lvdEnableOpt, .lvdLevelOpt,
    .wdgUnderflow, .cpuIntMask, .irqAck, .haltMode, .waitMode, .warnIrq,
    .waitWake, .coreReset_b, .lvdLevel, .lvdEnable, .rstPinOut, .rstPinOe_b);
  ssr_pin_model pin (.rstPinOe_b, .extLow, .pinHigh);
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    sel <= 1;
    addr <= a;
    trans <= 2'h2;
    wr <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    sel <= 0;
    trans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] e);
    bus(0, 0, 0);
    chk("status", rd, {24'h0, e});
    chk("hresp", {31'h0, hresp}, 0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for the pin to be released, then settle
  task automatic waitRel;
    for (int i = 0; i < 100 && rstPinOe_b !== 1'b1; i++) @(posedge clk);
    cyc(8);
  endtask
  task automatic wdgPulse;
    wdgUnderflow <= 1;
    @(posedge clk);
    wdgUnderflow <= 0;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(5000);
    fails++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    cyc(4);
    rst_b <= 1;
    waitRel();
    chk("coreReset_b", coreReset_b, 1);
    rdChk(8'h00);
    sup[0] <= 1;
    cyc(8);
    rdChk(8'h08);
    bus(1, 0, 32'hff);
    rdChk(8'h48);
    waitMode <= 1;
    sup[2:1] <= 2'b10;
    cyc(8);
    chk("warnIrq", warnIrq, 1);
    chk("waitWake", waitWake, 1);
    rdChk(8'h68);
    cpuIntMask <= 1;
    haltMode <= 1;
    cyc(2);
    chk("masked", warnIrq, 0);
    chk("haltWake", waitWake, 0);
    bus(1, 0, 0);
    sup[2:1] <= 2'b01;
    cyc(8);
    rdChk(8'h68);
    haltMode <= 0;
    cyc(4);
    rdChk(8'h48);
    cpuIntMask <= 0;
    cyc(2);
    chk("pending", warnIrq, 1);
    irqAck <= 1;
    @(posedge clk);
    irqAck <= 0;
    cyc(2);
    chk("acked", warnIrq, 0);
    wdgPulse();
    cyc(2);
    chk("wdgPin", pinHigh, 0);
    waitRel();
    rdChk(8'h49);
    bus(1, 0, 32'h10);
    rdChk(8'h08);
    wdgPulse();
    waitRel();
    sup[4:3] <= 2'b00;
    cyc(8);
    chk("lvdPin", pinHigh, 0);
    sup[3] <= 1;
    cyc(12);
    chk("lvdHold", coreReset_b, 0);
    sup[4] <= 1;
    waitRel();
    rdChk(8'h18);
    wdgPulse();
    waitRel();
    rdChk(8'h19);
    extLow <= 1;
    cyc(6);
    extLow <= 0;
    waitRel();
    rdChk(8'h19);
    bus(1, 0, 0);
    rdChk(8'h08);
    bus(0, 32'h4, 0);
    chk("unmapped", rd, 0);
    for (int l = 0; l < 4; l++) begin
      lvdLevelOpt <= l[1:0];
      cyc(3);
      chk("lvdLevel", {30'h0, lvdLevel}, (l == 3) ? 0 : l);
    end
    lvdEnableOpt <= 0;
    sup[2:1] <= 2'b10;
    cyc(8);
    bus(0, 0, 0);
    chk("warnOff", rd & 32'h20, 0);
    chk("lvdEnable", {31'h0, lvdEnable}, 0);
    end_of_test();
  end
endmodule
bind ssr_supervisor ssr_supervisor_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk_i (
  .clk, .rst_b, .hrdata, .sense, .lvdEnableOpt, .lvdLevelOpt, .wdgUnderflow,
  .cpuIntMask, .irqAck, .haltMode, .waitMode, .warnIrq, .waitWake,
  .coreReset_b, .lvdLevel, .lvdEnable, .rstPinOut, .rstPinOe_b);
`default_nettype wire
